// ---- rtl/gpm_ctrl.sv ----
// Top of the general I/O and peripheral mux controller: register slave, line muxing,
// pin change detection and the interrupt output.
// Assumes the bridge and peripherals run on clk_sys; pads are asynchronous.
`timescale 1ns/1ns
module gpm_ctrl #(
    parameter int NUM_LINES = 32,
    parameter logic [NUM_LINES-1:0] PERIPH_PRESENT = '1,
    parameter logic [NUM_LINES-1:0] OWNER_RST = NUM_LINES'(gpm_pkg::RST_OWNER_STATUS),
    parameter logic [NUM_LINES-1:0] DIR_RST = NUM_LINES'(gpm_pkg::RST_DIR_STATUS)
) (
    input logic clk_sys, // System clock, 25 MHz
    input logic resetn, // Primary reset, low active, synchronous
    input logic resetn_f, // Falling-edge reset, low active
    input logic ui_clk_en, // User-interface clock enable from bridge
    input gpm_pkg::gpm_bus_req_s bus_req, // Bridge request
    output logic [31:0] bus_rdata, // Read data, cycle after read
    input logic [NUM_LINES-1:0] pad_in, // Levels from pads
    output logic [NUM_LINES-1:0] pad_out, // Levels to pads
    output logic [NUM_LINES-1:0] pad_drive_n, // Pad drive enable, low drives
    input logic [NUM_LINES-1:0] periph_out, // Data from peripherals
    input logic [NUM_LINES-1:0] periph_drive_n, // Peripheral drive enable, low drives
    output logic [NUM_LINES-1:0] periph_in_data, // Data to peripherals
    output logic change_irq // Interrupt, high active
);
    import gpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [13:0] word_addr;
    logic wr_hit;
    logic rd_hit;
    logic owner_set_we;
    logic owner_clr_we;
    logic dir_set_we;
    logic dir_clr_we;
    logic level_set_we;
    logic level_clr_we;
    logic mask_set_we;
    logic mask_clr_we;
    logic change_rd;
    logic [NUM_LINES-1:0] owner_q;
    logic [NUM_LINES-1:0] dir_q;
    logic [NUM_LINES-1:0] out_level_q;
    logic [NUM_LINES-1:0] mask_q;
    logic [NUM_LINES-1:0] pin_level;
    logic [NUM_LINES-1:0] pin_prev_ff;
    logic [NUM_LINES-1:0] pin_chg;
    logic [NUM_LINES-1:0] change_ff;
    logic [NUM_LINES-1:0] nxt_change;
    logic [NUM_LINES-1:0] nxt_pad_out;
    logic [NUM_LINES-1:0] nxt_pad_drive_n;
    logic [NUM_LINES-1:0] nxt_periph_in;
    logic [NUM_LINES-1:0] pad_out_ff;
    logic [NUM_LINES-1:0] pad_drive_n_ff;
    logic [NUM_LINES-1:0] periph_in_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    logic change_irq_ff;
    logic [NUM_LINES-1:0] wbits;

    // Zero-extend a line vector to the bus width; upper bits read as zero
    function automatic logic [31:0] ext(input logic [NUM_LINES-1:0] v);
        ext = 32'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // The two low address bits are dropped before comparing against offsets
    assign word_addr = {bus_req.addr[13:2], 2'b00};
    assign wr_hit = bus_req.sel & bus_req.stb & bus_req.write;
    assign rd_hit = bus_req.sel & bus_req.stb & ~bus_req.write;

    // Only lines that exist take part in writes
    assign wbits = bus_req.wdata[NUM_LINES-1:0];

    // Write strobes to the set/clear pairs; read-only offsets decode to nothing
    assign owner_set_we = wr_hit && (word_addr == OFS_OWNER_SW_SET);
    assign owner_clr_we = wr_hit && (word_addr == OFS_OWNER_SW_CLEAR);
    assign dir_set_we = wr_hit && (word_addr == OFS_DIR_OUT_SET);
    assign dir_clr_we = wr_hit && (word_addr == OFS_DIR_OUT_CLEAR);
    assign level_set_we = wr_hit && (word_addr == OFS_OUT_LEVEL_SET);
    assign level_clr_we = wr_hit && (word_addr == OFS_OUT_LEVEL_CLEAR);
    assign mask_set_we = wr_hit && (word_addr == OFS_CHANGE_MASK_SET);
    assign mask_clr_we = wr_hit && (word_addr == OFS_CHANGE_MASK_CLEAR);
    assign change_rd = rd_hit && (word_addr == OFS_CHANGE_STATUS);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Ownership: one means software control; lines without a peripheral stay at one
    gpm_setclr_reg #(
        .WIDTH(NUM_LINES),
        .RST_VAL(OWNER_RST),
        .WR_MASK(PERIPH_PRESENT),
        .FORCE_ONE(~PERIPH_PRESENT)
    ) u_owner (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ui_clk_en(ui_clk_en),
        .set_we(owner_set_we),
        .clr_we(owner_clr_we),
        .wdata(wbits),
        .status(owner_q)
    );

    // Direction: one means output when under software control
    gpm_setclr_reg #(
        .WIDTH(NUM_LINES),
        .RST_VAL(DIR_RST),
        .WR_MASK('1),
        .FORCE_ONE('0)
    ) u_dir (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ui_clk_en(ui_clk_en),
        .set_we(dir_set_we),
        .clr_we(dir_clr_we),
        .wdata(wbits),
        .status(dir_q)
    );

    // Output level driven by software lines
    gpm_setclr_reg #(
        .WIDTH(NUM_LINES),
        .RST_VAL(NUM_LINES'(RST_OUT_LEVEL)),
        .WR_MASK('1),
        .FORCE_ONE('0)
    ) u_level (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ui_clk_en(ui_clk_en),
        .set_we(level_set_we),
        .clr_we(level_clr_we),
        .wdata(wbits),
        .status(out_level_q)
    );

    // Interrupt mask
    gpm_setclr_reg #(
        .WIDTH(NUM_LINES),
        .RST_VAL(NUM_LINES'(RST_CHANGE_MASK)),
        .WR_MASK('1),
        .FORCE_ONE('0)
    ) u_mask (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ui_clk_en(ui_clk_en),
        .set_we(mask_set_we),
        .clr_we(mask_clr_we),
        .wdata(wbits),
        .status(mask_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling and change detection

    // Pads are asynchronous, so two stages come before any logic
    gpm_pin_sync #(
        .WIDTH(NUM_LINES)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .resetn_f(resetn_f),
        .din(pad_in),
        .dout(pin_level)
    );

    // Previous level; a high pin after reset shows as a first change
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            pin_prev_ff <= '0;
        else
            pin_prev_ff <= pin_level;
    end

    assign pin_chg = pin_level ^ pin_prev_ff;

    // A change in the read cycle survives the clear, so no event is lost
    always_comb
    begin
        nxt_change = change_ff;
        if (change_rd)
            nxt_change = '0;
        nxt_change = nxt_change | pin_chg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            change_ff <= NUM_LINES'(RST_CHANGE_STATUS);
        else
            change_ff <= nxt_change;
    end

    // Masked flags of every line gate into one output
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            change_irq_ff <= 1'b0;
        else
            change_irq_ff <= |(change_ff & mask_q);
    end

    assign change_irq = change_irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Line multiplexing

    // Per line: software or peripheral owns the pad
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++)
        begin : g_line
            always_comb
            begin
                if (owner_q[gi])
                begin
                    nxt_pad_out[gi] = out_level_q[gi];
                    nxt_pad_drive_n[gi] = ~dir_q[gi];
                    nxt_periph_in[gi] = 1'b0;
                end
                else
                begin
                    nxt_pad_out[gi] = periph_out[gi];
                    nxt_pad_drive_n[gi] = periph_drive_n[gi];
                    nxt_periph_in[gi] = pin_level[gi];
                end
            end
        end
    endgenerate

    // Registered outputs; costs one cycle but keeps pads glitch-free
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pad_out_ff <= '0;
            pad_drive_n_ff <= '1;
            periph_in_ff <= '0;
        end
        else
        begin
            pad_out_ff <= nxt_pad_out;
            pad_drive_n_ff <= nxt_pad_drive_n;
            periph_in_ff <= nxt_periph_in;
        end
    end

    assign pad_out = pad_out_ff;
    assign pad_drive_n = pad_drive_n_ff;
    assign periph_in_data = periph_in_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    // Write-only and unmapped offsets read as zero
    always_comb
    begin
        unique case (word_addr)
            OFS_OWNER_STATUS: nxt_rdata = ext(owner_q);
            OFS_DIR_STATUS: nxt_rdata = ext(dir_q);
            OFS_OUT_LEVEL_STATUS: nxt_rdata = ext(out_level_q);
            OFS_PIN_LEVEL_STATUS: nxt_rdata = ext(pin_level);
            OFS_CHANGE_MASK: nxt_rdata = ext(mask_q);
            OFS_CHANGE_STATUS: nxt_rdata = ext(change_ff);
            default: nxt_rdata = RST_READ_DATA;
        endcase
    end

    // Data stands only in the cycle after the read
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            rdata_ff <= RST_READ_DATA;
        else if (rd_hit)
            rdata_ff <= nxt_rdata;
        else
            rdata_ff <= RST_READ_DATA;
    end

    assign bus_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_change_read;
        change_rd && (pin_chg == '0);
    endsequence

    sequence s_read_owner;
        rd_hit && (word_addr == OFS_OWNER_STATUS);
    endsequence

    chk_read_owner_data: assert property (
        s_read_owner |=> (bus_rdata == ext($past(owner_q))))
        else $error("owner status read returned wrong data");

    chk_idle_read_zero: assert property (
        !$past(rd_hit) |-> (bus_rdata == 32'h00000000))
        else $error("read data not zero outside a read");

    chk_change_cleared: assert property (
        s_change_read ##1 (pin_chg == '0) |=> (change_ff == '0))
        else $error("change status not cleared after read");

    chk_change_sets: assert property (
        (pin_chg != '0) |=> ((change_ff & $past(pin_chg)) == $past(pin_chg)))
        else $error("pin change did not set its flag");

    chk_irq_gate: assert property (
        ##1 (change_irq == |($past(change_ff) & $past(mask_q))))
        else $error("interrupt does not follow masked flags");

    chk_sw_input_float: assert property (
        ##1 ((pad_drive_n | ~$past(owner_q) | $past(dir_q)) == '1))
        else $error("software input line drives its pad");

    chk_periph_drive: assert property (
        ##1 (((pad_drive_n ^ $past(periph_drive_n)) & ~$past(owner_q)) == '0))
        else $error("peripheral line ignores peripheral enable");

    chk_periph_zero: assert property (
        ##1 ((periph_in_data & $past(owner_q)) == '0))
        else $error("software line leaks data to peripheral");

    chk_pad_level: assert property (
        ##1 (((pad_out ^ $past(out_level_q)) & $past(owner_q)) == '0))
        else $error("software line pad level differs from level bit");

    chk_fixed_owner: assert property (
        (~owner_q & ~PERIPH_PRESENT) == '0)
        else $error("line without peripheral lost software ownership");

    chk_dir_set_write: assert property (
        (dir_set_we && ui_clk_en) |=> ((dir_q & $past(wbits)) == $past(wbits)))
        else $error("direction set write did not set bits");

    chk_reset_default: assert property (@(posedge clk_sys) disable iff (1'b0)
        !resetn |=> ((owner_q == (OWNER_RST | ~PERIPH_PRESENT)) && (dir_q == DIR_RST)))
        else $error("reset did not restore default line setup");

endmodule

// ---- rtl/gpm_pin_sync.sv ----
// Two-stage synchroniser for the pad inputs: falling-edge first stage, rising-edge second.
// Assumes the pads are asynchronous to clk_sys and both resets are released cleanly.
`timescale 1ns/1ns
module gpm_pin_sync #(
    parameter int WIDTH = 32
) (
    input logic clk_sys, // System clock
    input logic resetn, // Rising-edge reset, low active
    input logic resetn_f, // Falling-edge reset, low active
    input logic [WIDTH-1:0] din, // Raw pad levels
    output logic [WIDTH-1:0] dout // Synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // First stage on the falling edge; only half a cycle to settle, traded for lower latency
    always_ff @(negedge clk_sys)
    begin
        if (!resetn_f)
            meta_ff <= '0;
        else
            meta_ff <= din;
    end

    // Second stage is the only reader of the first
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            stable_ff <= '0;
        else
            stable_ff <= meta_ff;
    end

    assign dout = stable_ff;
endmodule

// ---- rtl/gpm_pkg.sv ----
// Constants, register map and bus carrier for the 32-line general I/O and peripheral mux controller.
// Assumes a single system clock at 25 MHz and a bridge that drives the carrier from the same clock.
package gpm_pkg;

    localparam int GPM_DATA_W = 32;
    localparam int GPM_ADDR_W = 14;

    // Byte offsets of the register map
    localparam logic [13:0] OFS_OWNER_SW_SET = 14'h0000;
    localparam logic [13:0] OFS_OWNER_SW_CLEAR = 14'h0004;
    localparam logic [13:0] OFS_OWNER_STATUS = 14'h0008;
    localparam logic [13:0] OFS_DIR_OUT_SET = 14'h0010;
    localparam logic [13:0] OFS_DIR_OUT_CLEAR = 14'h0014;
    localparam logic [13:0] OFS_DIR_STATUS = 14'h0018;
    localparam logic [13:0] OFS_OUT_LEVEL_SET = 14'h0030;
    localparam logic [13:0] OFS_OUT_LEVEL_CLEAR = 14'h0034;
    localparam logic [13:0] OFS_OUT_LEVEL_STATUS = 14'h0038;
    localparam logic [13:0] OFS_PIN_LEVEL_STATUS = 14'h003c;
    localparam logic [13:0] OFS_CHANGE_MASK_SET = 14'h0040;
    localparam logic [13:0] OFS_CHANGE_MASK_CLEAR = 14'h0044;
    localparam logic [13:0] OFS_CHANGE_MASK = 14'h0048;
    localparam logic [13:0] OFS_CHANGE_STATUS = 14'h004c;

    // Values after reset
    localparam logic [31:0] RST_OWNER_STATUS = 32'hffffffff;
    localparam logic [31:0] RST_DIR_STATUS = 32'h00000000;
    localparam logic [31:0] RST_OUT_LEVEL = 32'h00000000;
    localparam logic [31:0] RST_CHANGE_MASK = 32'h00000000;
    localparam logic [31:0] RST_CHANGE_STATUS = 32'h00000000;
    localparam logic [31:0] RST_READ_DATA = 32'h00000000;

    // One bus request from the bridge
    typedef struct packed {
        logic sel;
        logic stb;
        logic write;
        logic [13:0] addr;
        logic [31:0] wdata;
    } gpm_bus_req_s;

endpackage

// ---- rtl/gpm_setclr_reg.sv ----
// One status register driven by a set register and a clear register, ones acting only.
// Assumes set and clear strobes come from the same clock and never together.
`timescale 1ns/1ns
module gpm_setclr_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RST_VAL = '0,
    parameter logic [WIDTH-1:0] WR_MASK = '1,
    parameter logic [WIDTH-1:0] FORCE_ONE = '0
) (
    input logic clk_sys, // System clock
    input logic resetn, // Synchronous reset, low active
    input logic ui_clk_en, // User-interface clock enable
    input logic set_we, // Write to the set register
    input logic clr_we, // Write to the clear register
    input logic [WIDTH-1:0] wdata, // Written bits
    output logic [WIDTH-1:0] status // Current status
);
    logic [WIDTH-1:0] status_ff;
    logic [WIDTH-1:0] nxt_status;

    // Ones set or clear, zeros and locked bits keep their value
    always_comb
    begin
        nxt_status = status_ff;
        if (set_we)
            nxt_status = status_ff | (wdata & WR_MASK);
        else if (clr_we)
            nxt_status = status_ff & ~(wdata & WR_MASK);
    end

    // Apart from reset, flops only move on the user-interface clock
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            status_ff <= RST_VAL;
        else if (ui_clk_en)
            status_ff <= nxt_status;
    end

    assign status = status_ff | FORCE_ONE;
endmodule

// ---- tb/gpm_far_model.sv ----
// Far side of the controller: on-chip peripherals and the pad wires.
// Assumes the bench picks the peripheral and off-chip levels it wants.
`timescale 1ns/1ns
module gpm_far_model #(
    parameter int NL = 24
) (
    input logic clk_sys, // System clock
    input logic [NL-1:0] ext_lvl, // Off-chip level on a floating pad
    input logic [NL-1:0] want_out, // Peripheral data wanted
    input logic [NL-1:0] want_dn, // Peripheral drive wanted, low drives
    input logic [NL-1:0] pad_out, // Data from the block
    input logic [NL-1:0] pad_drive_n, // Pad drive from the block, low drives
    output logic [NL-1:0] pad_in, // Resolved pad level
    output logic [NL-1:0] periph_out, // Peripheral data
    output logic [NL-1:0] periph_drive_n // Peripheral drive, low drives
);
////////////////////////////////////////////////////////////////////////
    // Peripherals launch after the edge, as real logic on clk_sys would
    always_ff @(posedge clk_sys)
    begin
        periph_out <= want_out;
        periph_drive_n <= want_dn;
    end
    // The block wins the wire when it drives, else the off-chip circuit
    assign pad_in = (~pad_drive_n & pad_out) | (pad_drive_n & ext_lvl);
endmodule

// ---- tb/test_gpm_ctrl.sv ----
// Self-checking bench for the I/O and peripheral mux controller.
// Assumes gpm_pkg and the far side model are compiled first.
`timescale 1ns/1ns
module test_gpm_ctrl;
    import gpm_pkg::*;
    localparam int NL = 24;
    localparam logic [NL-1:0] PRES = 24'h0f0f0f;
    localparam logic [31:0] L = 32'h00ffffff;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic resetn_f = 1'b0;
    logic ui_clk_en = 1'b1;
    gpm_bus_req_s bus_req = '0;
    logic [31:0] bus_rdata;
    logic [NL-1:0] pad_in, pad_out, pad_drive_n, periph_out, periph_drive_n, periph_in_data;
    logic [NL-1:0] ext = '0, p_out = '0, p_dn = '1;
    logic change_irq;
    logic [31:0] st[4];
    logic [13:0] base[4] = '{OFS_OWNER_SW_SET, OFS_DIR_OUT_SET, OFS_OUT_LEVEL_SET, OFS_CHANGE_MASK_SET};
    int bad_count = 0, checks = 0, cyc = 0;
////////////////////////////////////////////////////////////////////////
    always #20 clk_sys = ~clk_sys;
    // Fewer lines than the maximum so the unbuilt bits are exercised
    gpm_ctrl #(.NUM_LINES(NL), .PERIPH_PRESENT(PRES)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .resetn_f(resetn_f), .ui_clk_en(ui_clk_en),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .pad_in(pad_in), .pad_out(pad_out),
        .pad_drive_n(pad_drive_n), .periph_out(periph_out), .periph_drive_n(periph_drive_n),
        .periph_in_data(periph_in_data), .change_irq(change_irq));
    gpm_far_model #(.NL(NL)) i_far (
        .clk_sys(clk_sys), .ext_lvl(ext), .want_out(p_out), .want_dn(p_dn),
        .pad_out(pad_out), .pad_drive_n(pad_drive_n), .pad_in(pad_in),
        .periph_out(periph_out), .periph_drive_n(periph_drive_n));
////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus cycles start and end just after a rising edge; one idle cycle follows a write, two follow a read
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        bus_req <= '{1'b1, 1'b1, 1'b1, a, d};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [13:0] a, output logic [31:0] v);
        bus_req <= '{1'b1, 1'b1, 1'b0, a, 32'h0};
        @(posedge clk_sys);
        bus_req <= '0;
        @(negedge clk_sys);
        v = bus_rdata;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("rdata idle", 32'h0, bus_rdata);
        @(posedge clk_sys);
    endtask
    // Lines without a peripheral always read as software owned
    function automatic logic [31:0] est(input int k);
        return (k == 0) ? ((st[0] | ~{8'h0, PRES}) & L) : (st[k] & L);
    endfunction
    // Pad and peripheral side levels follow from the modelled registers
    task automatic chk_pins();
        logic [NL-1:0] own, drv, dout, pin;
        own = NL'(est(0));
        drv = (own & ~NL'(st[1])) | (~own & p_dn);
        dout = (own & NL'(st[2])) | (~own & p_out);
        pin = (~drv & dout) | (drv & ext);
        @(negedge clk_sys);
        cmp("pad_drive_n", 32'(drv), 32'(pad_drive_n));
        cmp("pad_out", 32'(~drv & dout), 32'(~drv & pad_out));
        cmp("periph_in_data", 32'(~own & pin), 32'(periph_in_data));
        @(posedge clk_sys);
    endtask
    task automatic chk_all();
        logic [31:0] v;
        for (int k = 0; k < 4; k++)
        begin
            rd(base[k] + 14'h8, v);
            cmp("status", est(k), v);
        end
        chk_pins();
    endtask
    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // A hang counts as a mismatch
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            $display("[ERR] timeout expected %0d seen %0d", 0, cyc);
            complete_run();
        end
    end
////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] v, d;
        int k;
        void'($urandom(56183));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        resetn_f <= 1'b1;
        @(posedge clk_sys);
        st = '{32'hffffffff, 32'h0, 32'h0, 32'h0};
        chk_all();
        rd(14'h000c, v);
        cmp("unmapped", 32'h0, v);
        // Without the user-interface clock nothing may move
        ui_clk_en <= 1'b0;
        wr(OFS_DIR_OUT_SET, 32'hffffffff);
        ui_clk_en <= 1'b1;
        chk_all();
        // All-ones direction set: every built line turns output, unbuilt bits stay clear
        wr(OFS_DIR_OUT_SET, 32'hffffffff);
        st[1] = 32'hffffffff;
        // Random set/clear traffic with stray low address bits
        for (int i = 0; i < 16; i++)
        begin
            k = $urandom_range(3);
            d = $urandom();
            if ($urandom_range(1))
            begin
                wr(base[k] | 14'($urandom_range(3)), d);
                st[k] = st[k] | d;
            end
            else
            begin
                wr((base[k] + 14'h4) | 14'($urandom_range(3)), d);
                st[k] = st[k] & ~d;
            end
            wr(base[$urandom_range(3)] + 14'h8, $urandom());
            ext <= NL'($urandom());
            p_out <= NL'($urandom());
            p_dn <= NL'($urandom());
            repeat (6) @(posedge clk_sys);
            chk_all();
        end
        // Change detection: inputs only, peripheral lines included
        wr(OFS_OWNER_SW_SET, 32'hffffffff);
        wr(OFS_OWNER_SW_CLEAR, 32'(PRES));
        wr(OFS_DIR_OUT_CLEAR, 32'hffffffff);
        st[0] = ~32'(PRES);
        st[1] = 32'h0;
        p_dn <= '1;
        ext <= '0;
        repeat (8) @(posedge clk_sys);
        rd(OFS_CHANGE_STATUS, v);
        d = $urandom() | 32'h1;
        wr(OFS_CHANGE_MASK_SET, d);
        st[3] = st[3] | d;
        v = 32'(NL'($urandom())) | 32'h00000011;
        ext <= NL'(v);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("change_irq", 32'(|(v & st[3] & L)), 32'(change_irq));
        @(posedge clk_sys);
        chk_pins();
        rd(OFS_PIN_LEVEL_STATUS, d);
        cmp("pin level", v, d);
        rd(OFS_CHANGE_STATUS, d);
        cmp("change status", v, d);
        rd(OFS_CHANGE_STATUS, d);
        cmp("change cleared", 32'h0, d);
        @(negedge clk_sys);
        cmp("change_irq", 32'h0, 32'(change_irq));
        @(posedge clk_sys);
        // Reset again in mid-run
        resetn <= 1'b0;
        resetn_f <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        resetn_f <= 1'b1;
        @(posedge clk_sys);
        st = '{32'hffffffff, 32'h0, 32'h0, 32'h0};
        chk_all();
        complete_run();
    end
endmodule
